// ### rps_seq.sv
// Power-up and power-down sequencer of the rectifier front end
// Overview of operation
// [R1] Thermistor bypass switch open from power application.
// [R2] Doubler strap switch open from power application.
// [R3] Converters disabled and bus-good warning high from power application.
// [R4] Doubler never activated while bus is above 200 V.
// [R5] Bypass closes only above 235 V once charge slope settles.
// [R6] Converters enabled about 150 ms after bypass closes.
// [R7] Bus-good warning asserted another 150 ms after converter enable.
// [R8] Warning de-asserted when bus decays below 205 V.
// [R9] Converters disabled when bus falls below 190 V.
// [R10] Power back after disable reruns the whole power-up sequence.
// [R11] Power back before disable threshold keeps running, no rerun.
// [R12] Warning driven low means normal bus, high means abnormal.
// [R13] Enable low disables converters, high enables them.
// [R14] Above 400 V disable converters and open bypass.
// [R15] Below 180 V open the bypass switch.
// [R16] Bus never above 200 V when settled: close doubler before bypass check.
// [R17] Delays counted on internal clock, cleared in initial state.
`timescale 1ns/1ps
module rps_seq #(
   // Step delay in clock cycles; only a bench shortens it
   parameter int unsigned STEP_CYC = rps_pkg::STEP_DELAY_CYC
) (
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   input  wire logic bus_above_180_i,
   input  wire logic bus_above_190_i,
   input  wire logic bus_above_200_i,
   input  wire logic bus_above_205_i,
   input  wire logic bus_above_235_i,
   input  wire logic bus_above_400_i,
   input  wire logic slope_settled_i,
   output logic      bypass_closed_o,
   output logic      doubler_closed_o,
   output logic      conv_enable_o,
   output logic      bus_good_warning_o
);
   // =====================================================
   // Input conditioning
   rps_sync_if sif ();
   logic gt180, gt190, gt200, gt205, gt235, gt400, settled;
   logic settled_q;
   logic settled_d;

   assign sif.raw = {bus_above_400_i, bus_above_235_i, bus_above_205_i,
                     bus_above_200_i, bus_above_190_i, bus_above_180_i};

   rps_sync u_sync (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .sif        (sif)
   );

   assign gt180 = sif.clean[0];
   assign gt190 = sif.clean[1];
   assign gt200 = sif.clean[2];
   assign gt205 = sif.clean[3];
   assign gt235 = sif.clean[4];
   assign gt400 = sif.clean[5];
   assign settled = settled_q;

   // =====================================================
   // Slope indication: own three-stage path with agreement filter
   logic [2:0] slp_q;
   logic [2:0] slp_d;
   always_comb begin
      slp_d     = {slp_q[1:0], slope_settled_i};
      settled_d = (slp_q[1] == slp_q[2]) ? slp_q[2] : settled_q;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         slp_q     <= 3'h0;
         settled_q <= 1'h0;
      end else begin
         slp_q     <= slp_d;
         settled_q <= settled_d;
      end
   end

   // =====================================================
   // Sequencer state
   rps_pkg::rps_state_t       state_q, state_d;
   logic [rps_pkg::DLY_W-1:0] dly_q, dly_d;
   logic                      byp_q, byp_d;
   logic                      dbl_q, dbl_d;
   logic                      en_q, en_d;
   logic                      bgw_q, bgw_d;
   logic                      dly_done;

   // One counter serves both steps; DLY_W holds the full-length count
   localparam logic [rps_pkg::DLY_W-1:0] DLY_LAST =
      rps_pkg::DLY_W'(STEP_CYC - 1);
   localparam logic [rps_pkg::DLY_W-1:0] DLY_ZERO = '0;
   localparam logic [rps_pkg::DLY_W-1:0] DLY_ONE  = rps_pkg::DLY_W'(1);

   assign dly_done = (dly_q == DLY_LAST);

   // =====================================================
   // Decisions taken on the filtered levels
   logic can_bypass;
   logic can_double;
   logic power_lost;

   assign can_bypass = settled && gt235 && !gt400;
   // Doubler only switched in; dropping it once the doubled bus passes 200 V would stall a low line
   assign can_double = (dbl_q == rps_pkg::SW_OPEN) && settled && !gt200;
   assign power_lost = (state_q != rps_pkg::RPS_ST_CHARGE) && (state_q != rps_pkg::RPS_ST_FAULT) && !gt190;

   always_comb begin
      state_d = state_q;
      dly_d   = dly_q;
      byp_d   = byp_q;
      dbl_d   = dbl_q;
      en_d    = en_q;
      bgw_d   = bgw_q;
      case (state_q)
         rps_pkg::RPS_ST_CHARGE: begin
            // Held at zero so every rerun waits a full step
            dly_d = DLY_ZERO;                                  // R17
            byp_d = rps_pkg::SW_OPEN;                          // R1
            en_d  = rps_pkg::EN_DISABLE_LVL;                   // R3 R13
            bgw_d = rps_pkg::BGW_ABNORM_LVL;                   // R3 R12
            if (can_double) begin
               dbl_d = rps_pkg::SW_CLOSED;                     // R4 R16
            end
            if (can_bypass) begin
               byp_d   = rps_pkg::SW_CLOSED;                   // R5
               state_d = rps_pkg::RPS_ST_BYPASS;
            end
         end
         rps_pkg::RPS_ST_BYPASS: begin
            dly_d = dly_q + DLY_ONE;                           // R17
            if (dly_done) begin
               dly_d   = DLY_ZERO;
               en_d    = rps_pkg::EN_ENABLE_LVL;               // R6 R13
               state_d = rps_pkg::RPS_ST_ENWAIT;
            end
         end
         rps_pkg::RPS_ST_ENWAIT: begin
            dly_d = dly_q + DLY_ONE;
            if (dly_done) begin
               dly_d   = DLY_ZERO;
               bgw_d   = rps_pkg::BGW_NORMAL_LVL;              // R7 R12
               state_d = rps_pkg::RPS_ST_RUN;
            end
         end
         rps_pkg::RPS_ST_RUN: begin
            if (!gt205) begin
               bgw_d   = rps_pkg::BGW_ABNORM_LVL;              // R8
               state_d = rps_pkg::RPS_ST_DECAY;
            end
         end
         rps_pkg::RPS_ST_DECAY: begin
            // Ride-through: bus recovers before disable threshold
            if (gt235) begin
               bgw_d   = rps_pkg::BGW_NORMAL_LVL;              // R11
               state_d = rps_pkg::RPS_ST_RUN;
            end
         end
         rps_pkg::RPS_ST_FAULT: begin
            // Hold everything off until the bus drops, then rerun from scratch
            byp_d = rps_pkg::SW_OPEN;
            en_d  = rps_pkg::EN_DISABLE_LVL;
            bgw_d = rps_pkg::BGW_ABNORM_LVL;
            if (!gt400) begin
               state_d = rps_pkg::RPS_ST_CHARGE;               // R10
            end
         end
         default: begin
            state_d = rps_pkg::RPS_ST_CHARGE;
         end
      endcase
      // Falling below 190 V ends the cycle; power return restarts from charge
      if (power_lost) begin
         en_d    = rps_pkg::EN_DISABLE_LVL;                    // R9 R13
         bgw_d   = rps_pkg::BGW_ABNORM_LVL;
         // Doubler back to its power-on position for the rerun
         dbl_d   = rps_pkg::SW_OPEN;                           // R2 R10
         dly_d   = DLY_ZERO;
         state_d = rps_pkg::RPS_ST_CHARGE;                     // R10
      end
      // Protection overrides everything, sticky until bus falls back
      if (!gt180) begin
         byp_d = rps_pkg::SW_OPEN;                             // R15
      end
      if (gt400) begin
         byp_d   = rps_pkg::SW_OPEN;                           // R14
         en_d    = rps_pkg::EN_DISABLE_LVL;                    // R14
         bgw_d   = rps_pkg::BGW_ABNORM_LVL;
         dbl_d   = rps_pkg::SW_OPEN;
         dly_d   = DLY_ZERO;
         state_d = rps_pkg::RPS_ST_FAULT;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q   <= rps_pkg::RPS_ST_CHARGE;
         dly_q     <= '0;
         byp_q     <= rps_pkg::SW_OPEN;                        // R1
         dbl_q     <= rps_pkg::SW_OPEN;                        // R2
         en_q      <= rps_pkg::EN_DISABLE_LVL;                 // R3
         bgw_q     <= rps_pkg::BGW_ABNORM_LVL;                 // R3
      end else begin
         state_q   <= state_d;
         dly_q     <= dly_d;
         byp_q     <= byp_d;
         dbl_q     <= dbl_d;
         en_q      <= en_d;
         bgw_q     <= bgw_d;
      end
   end

   // =====================================================
   // Outputs straight from the sequencer flops
   assign bypass_closed_o    = byp_q;
   assign doubler_closed_o   = dbl_q;
   assign conv_enable_o      = en_q;
   assign bus_good_warning_o = bgw_q;
endmodule

// ### rps_pkg.sv
// Package of constants and types for the rectifier power sequencer
package rps_pkg;
   // =====================================================
   // Timing
   localparam int unsigned CLK_PERIOD_PS    = 5000;
   localparam int unsigned STEP_DELAY_MS    = 150;
   // Cycles per millisecond first: the product in picoseconds overflows 32 bits
   localparam int unsigned CYC_PER_MS       = 1000000000 / CLK_PERIOD_PS;
   localparam int unsigned STEP_DELAY_CYC   = STEP_DELAY_MS * CYC_PER_MS;
   localparam int unsigned DLY_W            = 25;
   // =====================================================
   // Output levels
   localparam logic EN_DISABLE_LVL  = 1'h0;
   localparam logic EN_ENABLE_LVL   = 1'h1;
   localparam logic BGW_NORMAL_LVL  = 1'h0;
   localparam logic BGW_ABNORM_LVL  = 1'h1;
   localparam logic SW_OPEN         = 1'h0;
   localparam logic SW_CLOSED       = 1'h1;
   // =====================================================
   // Sequencer states, Gray coded along the power-up path
   typedef enum logic [2:0] {
      RPS_ST_CHARGE = 3'h0,
      RPS_ST_BYPASS = 3'h1,
      RPS_ST_ENWAIT = 3'h3,
      RPS_ST_RUN    = 3'h2,
      RPS_ST_DECAY  = 3'h6,
      RPS_ST_FAULT  = 3'h7
   } rps_state_t;
endpackage

// ### rps_sync_if.sv
// Interface carrying raw and filtered comparator levels to and from the input filter
`timescale 1ns/1ps
interface rps_sync_if;
   logic [5:0] raw;
   logic [5:0] clean;
   modport filt (input raw, output clean);
   modport user (output raw, input clean);
endinterface

// ### rps_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module rps_sync (
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   rps_sync_if.filt  sif
);
   logic [5:0] s1_q;
   logic [5:0] s2_q;
   logic [5:0] s3_q;
   logic [5:0] clean_q;
   logic [5:0] clean_d;

   // Change accepted only once stages two and three agree
   always_comb begin
      clean_d = clean_q;
      for (int i = 0; i < 6; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            clean_d[i] = s3_q[i];
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q    <= 6'h00;
         s2_q    <= 6'h00;
         s3_q    <= 6'h00;
         clean_q <= 6'h00;
      end else begin
         s1_q    <= sif.raw;
         s2_q    <= s1_q;
         s3_q    <= s2_q;
         clean_q <= clean_d;
      end
   end

   assign sif.clean = clean_q;
endmodule

// ### rps_conv_model.sv
// Downstream converter model driven by the enable and warning lines
`timescale 1ns/1ps
module rps_conv_model (
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   input  wire logic conv_enable_i,
   input  wire logic bus_good_warning_i,
   output logic      conv_running_o,
   output logic      shutdown_ok_o
);
   // ==========================================
   // Converter runs only while enable is high
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         conv_running_o <= 1'h0;
      end else begin
         conv_running_o <= conv_enable_i;
      end
   end
   // Warning high means abnormal bus
   assign shutdown_ok_o = bus_good_warning_i;
endmodule

// ### rps_seq_properties.sv
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
module rps_seq_properties #(
   parameter int unsigned STEP_CYC = rps_pkg::STEP_DELAY_CYC
) (
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   input  wire logic bus_above_180_i,
   input  wire logic bus_above_190_i,
   input  wire logic bus_above_200_i,
   input  wire logic bus_above_205_i,
   input  wire logic bus_above_235_i,
   input  wire logic bus_above_400_i,
   input  wire logic slope_settled_i,
   input  wire logic bypass_closed_o,
   input  wire logic doubler_closed_o,
   input  wire logic conv_enable_o,
   input  wire logic bus_good_warning_o
);
   // Slack of two cycles on the long delays
   localparam int unsigned MIN_STEP = STEP_CYC - 2;
   logic [24:0] byp_cnt_q;
   logic [24:0] en_cnt_q;
   // ==========================================
   // Saturating age counters
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         byp_cnt_q <= 25'h0;
         en_cnt_q  <= 25'h0;
      end else begin
         byp_cnt_q <= !bypass_closed_o ? 25'h0 : byp_cnt_q + {24'h0, byp_cnt_q != 25'h1ffffff};
         en_cnt_q  <= !conv_enable_o ? 25'h0 : en_cnt_q + {24'h0, en_cnt_q != 25'h1ffffff};
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   // ==========================================
   // Properties
   a_reset_state: assert property ($rose(rst_n_i) |->
      !bypass_closed_o && !doubler_closed_o && !conv_enable_o && bus_good_warning_o) else $error("bad reset state");
   a_doubler_high_bus: assert property (bus_above_200_i[*8] |-> !$rose(doubler_closed_o))
      else $error("doubler closed above 200");
   a_bypass_low_bus: assert property (!bus_above_235_i[*8] |-> !$rose(bypass_closed_o))
      else $error("bypass closed below 235");
   a_enable_delay: assert property ($rose(conv_enable_o) |-> bypass_closed_o && byp_cnt_q >= MIN_STEP)
      else $error("enable too early");
   a_warning_delay: assert property ($fell(bus_good_warning_o) |-> en_cnt_q >= MIN_STEP)
      else $error("warning asserted too early");
   a_warn_decay: assert property (!bus_above_205_i[*8] |-> bus_good_warning_o)
      else $error("warning low below 205");
   a_disable_decay: assert property (!bus_above_190_i[*8] |-> !conv_enable_o)
      else $error("enable high below 190");
   a_over_volt: assert property (bus_above_400_i[*8] |-> !conv_enable_o && !bypass_closed_o)
      else $error("no overvoltage shutdown");
   a_under_bypass: assert property (!bus_above_180_i[*8] |-> !bypass_closed_o)
      else $error("bypass closed below 180");
endmodule
bind rps_seq rps_seq_properties #(.STEP_CYC(STEP_CYC)) u_rps_seq_properties (.*);

// ### tb_rectifier_power_sequencer.sv
// Self-checking bench for the rectifier power sequencer
`timescale 1ns/1ps
module tb_rectifier_power_sequencer;
   // Short step so the bench reaches the running state
   localparam int unsigned TB_STEP = 200;
   logic       shut_ok;
   logic       core_clk_i;
   logic       rst_n_i;
   logic [6:0] in_q;
   wire  [3:0] outs;
   logic       running;
   int         errors;
   int         cmp_count;
   // ==========================================
   // Bits: 0..5 above 180/190/200/205/235/400, 6 settled
   rps_seq #(.STEP_CYC(TB_STEP)) u_rps_seq (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .bus_above_180_i(in_q[0]),
      .bus_above_190_i(in_q[1]), .bus_above_200_i(in_q[2]), .bus_above_205_i(in_q[3]),
      .bus_above_235_i(in_q[4]), .bus_above_400_i(in_q[5]), .slope_settled_i(in_q[6]),
      .bypass_closed_o(outs[0]), .doubler_closed_o(outs[1]), .conv_enable_o(outs[2]),
      .bus_good_warning_o(outs[3]));
   rps_conv_model u_rps_conv_model (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .conv_enable_i(outs[2]),
      .bus_good_warning_i(outs[3]), .conv_running_o(running), .shutdown_ok_o(shut_ok));
   initial begin
      core_clk_i = 1'h0;
      forever #2.5 core_clk_i = ~core_clk_i;
   end
   task automatic chk(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t: output mismatch", $time);
      end
   endtask
   // Bounded wait on one output, then compare
   task automatic wait_out(input int idx, input logic exp);
      #1;
      for (int i = 0; i < 64 && outs[idx] !== exp; i++) begin
         @(posedge core_clk_i);
         #1;
      end
      chk(outs[idx], exp);
   endtask
   task automatic apply_reset();
      @(posedge core_clk_i) rst_n_i <= 1'h0;
      in_q <= 7'h00;
      repeat (4) @(posedge core_clk_i);
      #1;
      chk(outs === 4'h8, 1'h1);
      @(posedge core_clk_i) rst_n_i <= 1'h1;
   endtask
   task automatic t_low_line();
      @(posedge core_clk_i) in_q <= 7'h45;
      repeat (16) @(posedge core_clk_i);
      #1;
      chk(outs[1], 1'h0);
      @(posedge core_clk_i) in_q <= 7'h41;
      wait_out(1, 1'h1);
      chk(outs[0], 1'h0);
      @(posedge core_clk_i) in_q <= 7'h0f;
      repeat (16) @(posedge core_clk_i);
      #1;
      chk(outs[1], 1'h1);
      chk(outs[0], 1'h0);
      @(posedge core_clk_i) in_q <= 7'h5f;
      wait_out(0, 1'h1);
      chk(outs[1], 1'h1);
   endtask
   task automatic t_power_up();
      @(posedge core_clk_i) in_q <= 7'h5f;
      wait_out(0, 1'h1);
      chk(outs[1], 1'h0);
      repeat (TB_STEP - 1) @(posedge core_clk_i);
      #1;
      chk(outs[2], 1'h0);
      @(posedge core_clk_i);
      #1;
      chk(outs[2], 1'h1);
      chk(running, 1'h0);
      repeat (TB_STEP - 1) @(posedge core_clk_i);
      #1;
      chk(running, 1'h1);
      chk(outs[3], 1'h1);
      @(posedge core_clk_i);
      #1;
      chk(outs[3], 1'h0);
   endtask
   task automatic t_ride_through();
      @(posedge core_clk_i) in_q <= 7'h07;
      wait_out(3, 1'h1);
      chk(outs[2], 1'h1);
      chk(shut_ok, 1'h1);
      @(posedge core_clk_i) in_q <= 7'h5f;
      wait_out(3, 1'h0);
      chk(outs[2], 1'h1);
      chk(outs[0], 1'h1);
   endtask
   task automatic t_brownout();
      @(posedge core_clk_i) in_q <= 7'h5e;
      wait_out(0, 1'h0);
   endtask
   task automatic t_power_loss();
      @(posedge core_clk_i) in_q <= 7'h01;
      wait_out(2, 1'h0);
      chk(outs[3], 1'h1);
      @(posedge core_clk_i) in_q <= 7'h1f;
      repeat (16) @(posedge core_clk_i);
      #1;
      chk(outs[2], 1'h0);
      @(posedge core_clk_i) in_q <= 7'h5f;
      wait_out(0, 1'h1);
      chk(outs[2], 1'h0);
   endtask
   task automatic t_overvolt();
      apply_reset();
      t_power_up();
      @(posedge core_clk_i) in_q <= 7'h7f;
      wait_out(0, 1'h0);
      chk(outs[2], 1'h0);
      chk(outs[3], 1'h1);
      @(posedge core_clk_i) in_q <= 7'h5f;
      wait_out(0, 1'h1);
      chk(outs[2], 1'h0);
   endtask
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Whole run is about 1000 cycles; limit is four times that
   initial begin
      repeat (TB_STEP * 20) @(posedge core_clk_i);
      errors++;
      end_of_test();
   end
   initial begin
      errors = 0;
      cmp_count = 0;
      rst_n_i = 1'h0;
      in_q = 7'h00;
      apply_reset();
      t_low_line();
      apply_reset();
      t_power_up();
      t_ride_through();
      t_brownout();
      t_power_loss();
      t_overvolt();
      end_of_test();
   end
endmodule
